/* File: hdl/scc_pkg.sv */
// Constants and types for the scratchpad to EEPROM copy handler
`default_nettype none
package scc_pkg;
  localparam logic [7:0] CMD_COPY_SCRATCH = 8'h5A;
  localparam int         PARAM_SU_BIT     = 7;
  localparam int         PARAM_PAGE_HI    = 5;
  localparam int         PARAM_PAGE_LO    = 4;
  localparam int         PARAM_FS_BIT     = 3;
  localparam int         PARAM_SEG_HI     = 2;
  localparam int         PARAM_SEG_LO     = 0;
  localparam int         SEG_BYTES        = 4;
  localparam int         SEGS_PER_PAGE    = 8;
  localparam int         PAGE_BYTES       = 32;
  localparam logic [4:0] SCRATCH_BASE     = 5'h00;
  localparam logic [3:0] PERIODS_FULL     = 4'h8;
  localparam logic [3:0] PERIODS_SEG      = 4'h1;
  localparam logic [1:0] PAGE_SEL0        = 2'h0;
  localparam logic [1:0] PAGE_SEL1        = 2'h1;
  localparam logic [1:0] RPTR_STATUS      = 2'h0;
  localparam int         CLK_MHZ          = 50;
  localparam int         PROG_TIME_US     = 10;
  localparam int         PROG_CYCLES      = PROG_TIME_US * CLK_MHZ;
  localparam int         TAIL_TIME_NS     = 1090;
  localparam int         TAIL_CYCLES_MAX  = (TAIL_TIME_NS * CLK_MHZ) / 1000;
  localparam logic [15:0] TAIL_CYCLES     = 16'(TAIL_CYCLES_MAX - 2);
  typedef enum logic [2:0] {ST_IDLE, ST_PARAM, ST_PROG, ST_TAIL} scc_state_t;
endpackage : scc_pkg
`default_nettype wire

/* File: hdl/scc_sync.sv */
// Two flip-flop synchroniser for one level
`timescale 1ns/10ps
`default_nettype none
module scc_sync (
  input  wire logic i_mclk,
  input  wire logic i_resetn,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_reg;
  // First stage feeds only the second
  // Resets to the pulled-up idle level, so no false edge follows reset
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_reg <= 1'b1;
      o_sync   <= 1'b1;
    end
    else
    begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule : scc_sync
`default_nettype wire

/* File: hdl/scc_scratch_mem.sv */
// Scratchpad and user EEPROM page storage with registered read
`timescale 1ns/10ps
`default_nettype none
module scc_scratch_mem (
  input  wire logic       i_mclk,
  input  wire logic       i_we,
  input  wire logic [5:0] i_waddr,
  input  wire logic [7:0] i_wdata,
  input  wire logic [5:0] i_raddr,
  output logic      [7:0] o_rdata
);
  logic [7:0] mem [0:63];
  // No reset on the array; contents are undefined until written
  always_ff @(posedge i_mclk)
  begin
    if (i_we)
      mem[i_waddr] <= i_wdata;
    o_rdata <= mem[i_raddr];
  end
endmodule : scc_scratch_mem
`default_nettype wire

/* File: hdl/scc_copy.sv */
// Copy-scratchpad command handler: programs scratchpad data into user pages
//
// Function
// - Command 5Ah then one parameter byte starts a copy.
// - Segment n takes scratchpad bytes 4n to 4n+3.
// - Protected target skips programming, stays not busy, acks next access.
// - Busy for one or eight program periods from parameter acknowledge.
// - Command ends within busy time plus 1.09 us; no status changes.
// - Command sets read pointer to master status register.
// - With bit 7 set, bits 5:4 select page 0 or 1 for the protection check only; bit 6 ignored.
// - Bit 3 zero copies whole page, one copies selected segment only.
// - Any protected block on the page forces segment mode.
// - Bits 2:0 pick the segment; all eight codes valid.
`timescale 1ns/10ps
`default_nettype none
module scc_copy
  import scc_pkg::*;
#(
  parameter int PROG_CYC = scc_pkg::PROG_CYCLES
) (
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic       i_scl,
  input  wire logic       i_byte_valid,
  input  wire logic [7:0] i_byte,
  input  wire logic       i_byte_is_cmd,
  input  wire logic       i_scr_we,
  input  wire logic [4:0] i_scr_addr,
  input  wire logic [7:0] i_scr_wdata,
  input  wire logic [1:0] i_page_protected,
  input  wire logic [1:0] i_page_part_protected,
  input  wire logic [5:0] i_rd_addr,
  output logic      [7:0] o_rd_data,
  output logic            o_byte_ack,
  output logic            o_busy,
  output logic            o_done,
  output logic      [1:0] o_read_ptr,
  output logic            o_prot_error
);
  import scc_pkg::*;

  typedef struct packed {
    scc_state_t  state;
    logic [1:0]  page;
    logic [2:0]  seg;
    logic [2:0]  seg_end;
    logic [1:0]  byte_idx;
    logic        wr_phase;
    logic [3:0]  periods;
    logic [15:0] cnt;
    logic        arm;
    logic        ack;
    logic        busy;
    logic        done;
    logic [1:0]  rptr;
    logic        perr;
  } scc_regs_t;

  scc_regs_t r_reg;
  scc_regs_t r_next;
  logic      scl_s;
  logic      scl_d_reg;
  logic      scl_rise;
  logic [7:0] rdata;
  logic       mem_we;
  logic [5:0] mem_waddr;
  logic [5:0] mem_raddr;
  logic [7:0] mem_wdata;
  logic [5:0] prog_raddr;
  logic       prog_active;

  // SCL from pin goes through two flops before edge detection
  scc_sync u_scl_sync (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_async  (i_scl),
    .o_sync   (scl_s)
  );

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      scl_d_reg <= 1'b1; // SCL idles high; matches the synchroniser reset
    else
      scl_d_reg <= scl_s;
  end
  assign scl_rise = scl_s & ~scl_d_reg;

  // Address 0..31 scratchpad, 32..63 one 32-byte page image written for both page 0 and page 1
  assign prog_active = (r_reg.state == ST_PROG);
  assign prog_raddr  = {1'b0, SCRATCH_BASE + {r_reg.seg, r_reg.byte_idx}};
  assign mem_raddr   = prog_active ? prog_raddr : i_rd_addr;
  assign mem_we      = prog_active ? r_reg.wr_phase : (i_scr_we & ~r_reg.busy);
  assign mem_waddr   = prog_active ? {1'b1, {r_reg.seg, r_reg.byte_idx}} : {1'b0, i_scr_addr};
  assign mem_wdata   = prog_active ? rdata : i_scr_wdata;

  scc_scratch_mem u_mem (
    .i_mclk  (i_mclk),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (mem_wdata),
    .i_raddr (mem_raddr),
    .o_rdata (rdata)
  );

  // Next-state logic for the whole command sequence
  always_comb
  begin
    logic full_copy;
    logic prot;
    full_copy = 1'b0;
    prot      = 1'b0;
    r_next      = r_reg;
    r_next.ack  = 1'b0;
    r_next.done = 1'b0;
    case (r_reg.state)
      ST_IDLE:
      begin
        if (i_byte_valid && i_byte_is_cmd && i_byte == CMD_COPY_SCRATCH)
        begin
          r_next.ack   = 1'b1;
          r_next.rptr  = RPTR_STATUS;
          r_next.state = ST_PARAM;
        end
      end
      ST_PARAM:
      begin
        if (i_byte_valid && i_byte_is_cmd)
          r_next.state = ST_IDLE;
        else if (i_byte_valid)
        begin
          // Bit 6 is never looked at
          if (!i_byte[PARAM_SU_BIT] || i_byte[PARAM_PAGE_HI])
          begin
            r_next.state = ST_IDLE;
          end
          else
          begin
            r_next.ack  = 1'b1;
            r_next.page = i_byte[PARAM_PAGE_HI:PARAM_PAGE_LO];
            prot = i_page_protected[i_byte[PARAM_PAGE_LO]];
            full_copy = ~i_byte[PARAM_FS_BIT]
                        & ~i_page_part_protected[i_byte[PARAM_PAGE_LO]];
            r_next.seg      = full_copy ? 3'h0 : i_byte[PARAM_SEG_HI:PARAM_SEG_LO];
            r_next.seg_end  = full_copy ? 3'(SEGS_PER_PAGE - 1) : i_byte[PARAM_SEG_HI:PARAM_SEG_LO];
            r_next.periods  = full_copy ? PERIODS_FULL : PERIODS_SEG;
            r_next.byte_idx = 2'h0;
            r_next.wr_phase = 1'b0;
            r_next.arm      = 1'b1;
            if (prot)
            begin
              r_next.perr  = 1'b1;
              r_next.state = ST_IDLE;
              r_next.done  = 1'b1;
            end
            else
            begin
              r_next.perr  = 1'b0;
              r_next.state = ST_PROG;
            end
          end
        end
      end
      ST_PROG:
      begin
        // Wait for acknowledge-bit SCL rise before timing begins
        if (r_reg.arm)
        begin
          if (scl_rise)
          begin
            r_next.arm  = 1'b0;
            r_next.busy = 1'b1;
            r_next.cnt  = 16'(PROG_CYC - 1);
          end
        end
        else
        begin
          r_next.wr_phase = ~r_reg.wr_phase;
          if (r_reg.wr_phase && r_reg.byte_idx != 2'(SEG_BYTES - 1))
            r_next.byte_idx = r_reg.byte_idx + 2'h1;
          else if (r_reg.wr_phase && r_reg.seg != r_reg.seg_end)
          begin
            r_next.byte_idx = 2'h0;
            r_next.seg      = r_reg.seg + 3'h1;
          end
          if (r_reg.cnt != 16'h0)
            r_next.cnt = r_reg.cnt - 16'h1;
          else if (r_reg.periods != 4'h1)
          begin
            r_next.periods = r_reg.periods - 4'h1;
            r_next.cnt     = 16'(PROG_CYC - 1);
          end
          else
          begin
            r_next.busy     = 1'b0;
            r_next.wr_phase = 1'b0;
            r_next.cnt      = TAIL_CYCLES;
            r_next.state    = ST_TAIL;
          end
        end
      end
      ST_TAIL:
      begin
        // Completion lands inside the 1.09 us allowance after busy drops
        if (r_reg.cnt != 16'h0)
          r_next.cnt = r_reg.cnt - 16'h1;
        else
        begin
          r_next.done  = 1'b1;
          r_next.state = ST_IDLE;
        end
      end
      default:
      begin
        r_next.state = ST_IDLE;
        r_next.busy  = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      r_reg       <= '0;
      r_reg.state <= ST_IDLE;
      r_reg.rptr  <= RPTR_STATUS;
    end
    else
      r_reg <= r_next;
  end

  // Read data registered so the output is a flop
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_rd_data <= 8'h00;
    else
      o_rd_data <= rdata;
  end

  assign o_byte_ack   = r_reg.ack;
  assign o_busy       = r_reg.busy;
  assign o_done       = r_reg.done;
  assign o_read_ptr   = r_reg.rptr;
  assign o_prot_error = r_reg.perr;
endmodule : scc_copy
`default_nettype wire

/* File: testbench/scc_copy_properties.sv */
// Port assertions for the copy handler
`timescale 1ns/10ps
`default_nettype none
module scc_copy_chk
  import scc_pkg::*;
#(
  parameter int PROG_CYC = 20
) (
  input wire logic       i_mclk,
  input wire logic       i_resetn,
  input wire logic       i_scl,
  input wire logic       i_byte_valid,
  input wire logic       o_byte_ack,
  input wire logic       o_busy,
  input wire logic       o_done,
  input wire logic [1:0] o_read_ptr,
  input wire logic       o_prot_error
);
  logic [15:0] bcnt_reg;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // Busy length, cleared when idle so each window counts alone
  always_ff @(posedge i_mclk or negedge i_resetn)
    if (!i_resetn)
      bcnt_reg <= '0;
    else
      bcnt_reg <= o_busy ? bcnt_reg + 16'h1 : '0;
  property p_ack_cause; o_byte_ack |-> $past(i_byte_valid); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without byte");
  property p_busy_len;
    $fell(o_busy) |-> bcnt_reg == 16'(PROG_CYC) || bcnt_reg == 16'(8 * PROG_CYC);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length");
  // Busy starts a fixed sync delay after the acknowledge clock rise on the pin
  property p_busy_start; $rose(o_busy) |-> $past(i_scl, 3) && !$past(i_scl, 4); endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not from ack clock");
  property p_busy_hold; $rose(o_busy) |-> o_busy[*8]; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
  property p_done_tail; $fell(o_busy) |-> ##[1:54] o_done; endproperty
  a_done_tail: assert property (p_done_tail) else $error("done late");
  property p_done_idle; o_done |-> !o_busy; endproperty
  a_done_idle: assert property (p_done_idle) else $error("done while busy");
  property p_prot_idle; $rose(o_prot_error) |-> !o_busy[*8]; endproperty
  a_prot_idle: assert property (p_prot_idle) else $error("busy on locked page");
  property p_rptr; o_done |-> o_read_ptr == RPTR_STATUS; endproperty
  a_rptr: assert property (p_rptr) else $error("read pointer");
  property p_busy_noack; o_busy |-> !o_byte_ack; endproperty
  a_busy_noack: assert property (p_busy_noack) else $error("ack while busy");
  c_full: cover property ($fell(o_busy) && bcnt_reg == 16'(8 * PROG_CYC));
  c_seg: cover property ($fell(o_busy) && bcnt_reg == 16'(PROG_CYC));
  c_prot: cover property ($rose(o_prot_error));
endmodule : scc_copy_chk
`default_nettype wire

/* File: testbench/scc_host.sv */
// Host model: sends bytes and the acknowledge clock
`timescale 1ns/10ps
`default_nettype none
module scc_host (
  input  wire logic       i_mclk,
  input  wire logic       i_ack,
  output logic            o_scl,
  output logic            o_valid,
  output logic            o_cmd,
  output logic      [7:0] o_byte
);
  initial {o_scl, o_valid, o_cmd, o_byte} = 11'h400;
  // One byte, then its ack clock rise; SCL rests high as pulled up
  task automatic send(input logic [7:0] b, input logic c, output logic a);
    @(posedge i_mclk);
    #1 o_scl = 1'b0;
    o_valid = 1'b1;
    o_byte = b;
    o_cmd = c;
    @(posedge i_mclk);
    #1 a = i_ack;
    o_valid = 1'b0;
    o_byte = ~b; // Released data line shows no stale value
    repeat (2) @(posedge i_mclk);
    #1 o_scl = 1'b1;
    // Ack clock stays high past the sync delay, as the next byte's bits follow later
    repeat (4) @(posedge i_mclk);
  endtask : send
endmodule : scc_host
`default_nettype wire

/* File: testbench/scc_copy_tb.sv */
// Self-checking bench for the copy handler
`timescale 1ns/10ps
`default_nettype none
module scc_copy_tb;
  import scc_pkg::*;
  localparam int PC = 20;
  logic       i_mclk, i_resetn, i_byte_valid, i_byte_is_cmd, i_scl, i_scr_we;
  logic [7:0] i_byte, i_scr_wdata, o_rd_data;
  logic [4:0] i_scr_addr;
  logic [5:0] i_rd_addr;
  logic [1:0] i_page_protected, i_page_part_protected, o_read_ptr;
  logic       o_byte_ack, o_busy, o_done, o_prot_error;
  logic [7:0] scr [32];
  logic [7:0] pg [32];
  int         err_count, checks, cyc, bsy, dn;
  scc_host scc_host_inst (.i_mclk(i_mclk), .i_ack(o_byte_ack), .o_scl(i_scl),
    .o_valid(i_byte_valid), .o_cmd(i_byte_is_cmd), .o_byte(i_byte));
  scc_copy #(.PROG_CYC(PC)) scc_copy_inst (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_scl(i_scl), .i_byte_valid(i_byte_valid), .i_byte(i_byte),
    .i_byte_is_cmd(i_byte_is_cmd), .i_scr_we(i_scr_we), .i_scr_addr(i_scr_addr),
    .i_scr_wdata(i_scr_wdata), .i_page_protected(i_page_protected),
    .i_page_part_protected(i_page_part_protected), .i_rd_addr(i_rd_addr),
    .o_rd_data(o_rd_data), .o_byte_ack(o_byte_ack), .o_busy(o_busy),
    .o_done(o_done), .o_read_ptr(o_read_ptr), .o_prot_error(o_prot_error));
  initial
  begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // Busy and done tally on the falling edge, clear of the launching edge
  always @(negedge i_mclk)
  begin
    bsy += int'(o_busy === 1'b1);
    dn += int'(o_done === 1'b1);
    if (++cyc > 20000)
    begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic fill(input logic [7:0] s);
    for (int i = 0; i < 32; i++)
    begin
      @(posedge i_mclk);
      #1 i_scr_we = 1'b1;
      i_scr_addr = 5'(i);
      scr[i] = 8'(i) ^ s;
      i_scr_wdata = scr[i];
    end
    @(posedge i_mclk);
    #1 i_scr_we = 1'b0;
  endtask : fill
  // n: busy cycles expected, 0 locked page, -1 refused parameter
  task automatic copy(input logic [7:0] p, input logic [1:0] pr, input logic [1:0] pp,
                      input int n);
    logic a;
    i_page_protected = pr;
    i_page_part_protected = pp;
    bsy = 0;
    dn = 0;
    scc_host_inst.send(CMD_COPY_SCRATCH, 1'b1, a);
    chk(a === 1'b1, "command ack");
    scc_host_inst.send(p, 1'b0, a);
    chk(a === (n >= 0), "parameter ack");
    repeat (260) @(posedge i_mclk);
    #1 chk(bsy == (n > 0 ? n : 0), "busy cycles");
    if (n >= 0)
    begin
      chk(dn == 1, "done count");
      chk(o_prot_error === (n == 0), "protect flag");
      chk(o_read_ptr === RPTR_STATUS, "read pointer");
    end
    for (int i = 0; i < 32; i++)
      if (n > 0 && (n == 8 * PC || i / 4 == int'(p[2:0])))
        pg[i] = scr[i];
  endtask : copy
  task automatic rd_chk;
    for (int i = 0; i < 32; i++)
    begin
      @(posedge i_mclk);
      #1 i_rd_addr = {1'b1, 5'(i)};
      repeat (2) @(posedge i_mclk);
      #1 chk(o_rd_data === pg[i], "page byte");
    end
  endtask : rd_chk
  task automatic finish_test;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  initial
  begin
    {i_resetn, i_scr_we, i_scr_addr, i_scr_wdata, i_rd_addr} = '0;
    {i_page_protected, i_page_part_protected} = '0;
    repeat (20) @(posedge i_mclk);
    #1 i_resetn = 1'b1;
    fill(8'hA5);
    copy(8'h90, 2'h0, 2'h0, 8 * PC);
    rd_chk();
    for (int s = 0; s < 8; s++)
    begin
      fill(8'(s * 8'h13));
      copy(8'hD8 + 8'(s), 2'h0, 2'h0, PC);
    end
    rd_chk();
    fill(8'h3C);
    copy(8'h80, 2'h0, 2'h1, PC);
    copy(8'h8B, 2'h1, 2'h0, 0);
    copy(8'hA0, 2'h0, 2'h0, -1);
    copy(8'h18, 2'h0, 2'h0, -1);
    rd_chk();
    finish_test();
  end
endmodule : scc_copy_tb
bind scc_copy scc_copy_chk #(.PROG_CYC(PROG_CYC)) chk_inst (.i_mclk(i_mclk),
  .i_resetn(i_resetn), .i_scl(i_scl), .i_byte_valid(i_byte_valid), .o_byte_ack(o_byte_ack),
  .o_busy(o_busy), .o_done(o_done), .o_read_ptr(o_read_ptr),
  .o_prot_error(o_prot_error));
`default_nettype wire
